// ### rtl/tmc_pkg.sv
// package: register map, field layout and types of the timer/counter block
package tmc_pkg;
    // register byte offsets
    localparam logic [7:0] TMC_CTRL_OFS  = 8'h00;
    localparam logic [7:0] TMC_CFG_OFS   = 8'h04;
    localparam logic [7:0] TMC_ALO_OFS   = 8'h08;
    localparam logic [7:0] TMC_AHI_OFS   = 8'h0c;
    localparam logic [7:0] TMC_BLO_OFS   = 8'h10;
    localparam logic [7:0] TMC_BHI_OFS   = 8'h14;
    localparam logic [7:0] TMC_CCTL_OFS  = 8'h18;
    localparam logic [7:0] TMC_CLO_OFS   = 8'h1c;
    localparam logic [7:0] TMC_CHI_OFS   = 8'h20;
    localparam logic [7:0] TMC_RLO_OFS   = 8'h24;
    localparam logic [7:0] TMC_RHI_OFS   = 8'h28;
    localparam logic [7:0] TMC_CAP0_OFS  = 8'h2c;
    localparam logic [7:0] TMC_CAP_STEP  = 8'h04;
    localparam int         TMC_NCAP      = 4;
    // timer_ab_control bit positions
    localparam int         TMC_TF_B_BIT  = 7;
    localparam int         TMC_TR_B_BIT  = 6;
    localparam int         TMC_TF_A_BIT  = 5;
    localparam int         TMC_TR_A_BIT  = 4;
    // reset values
    localparam logic [7:0]  TMC_RST_BYTE = 8'h00;
    localparam logic [15:0] TMC_RST_WORD = 16'h0000;
    // prescaler: one tick every 12 clocks
    localparam int         TMC_DIV_BASE  = 12;
    localparam logic [3:0] TMC_PRESC_LAST = 4'(TMC_DIV_BASE - 1);
    localparam logic [3:0] TMC_PRESC_ZERO = 4'h0;
    // timer_c reload mode encodings
    localparam logic [1:0] TMC_RLD_M0    = 2'h2;
    localparam logic [1:0] TMC_RLD_M1    = 2'h3;

    typedef enum logic [1:0] {TMC_M13, TMC_M16, TMC_M8R, TMC_SPLIT} tmc_mode_t;
    typedef enum logic [1:0] {TMC_C_STOP, TMC_C_CLK, TMC_C_EVT, TMC_C_GATED} tmc_csel_t;

    typedef struct packed {
        logic      gate;
        logic      ct;
        tmc_mode_t mode;
    } tmc_ab_cfg_t;

    typedef struct packed {
        logic      ps;
        logic [1:0] edge_sel;
        logic [1:0] rmode;
        logic      cmp_mode;
        tmc_csel_t sel;
    } tmc_c_ctl_t;
endpackage

// ### rtl/tmc_timers.sv
// timers a, b and c with apb register access and pin synchronisers
`timescale 1ns/1ps
// Notes on behaviour
// - timer mode: a and b advance once every 12 clocks
// - counter mode: a and b advance on falling edge of own count pin
// - falling edge detection takes two clocks, max rate a quarter of the clock
// - a and b values readable as high byte and low byte
// - mode zero: 13-bit count, low byte bits 7..5 unchanged
// - mode one: full 16-bit counting
// - mode two: 8-bit low count reloaded from high byte on overflow
// - mode three: a splits into two 8-bit counts, b holds its count
// - while a is split, b keeps running in its other modes
// - c has four capture registers and one 16-bit reload register
// - c input select 01 counts prescaled processor clock
// - prescale select 0 gives 12 clocks per step, 1 gives 24
// - c input select 10 counts falling edges of third count pin
// - c pin sampled every clock, count steps the cycle after detection
// - c input select 11 counts prescaled clock only while pin high
// - reload mode zero: c overflow loads the reload value
// - reload mode one: falling reload trigger loads the reload value
// - reload trigger is low frequency clock divided by two
// - a/b mode field: 00 13-bit, 01 16-bit, 10 reload, 11 split
// - a/b overflow flags set on own overflow, b flag on a high byte overflow while a split, cleared on service entry
// - c input select: 00 stop, 01 clock, 10 edges, 11 gated
// - c reload mode field: 0x off, 10 mode zero, 11 mode one
module tmc_timers (
    // clock and reset
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    // apb slave
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [7:0]  paddr,
    input  wire  logic [31:0] pwdata,
    output logic       [31:0] prdata,
    output logic              pready,
    output logic              pslverr,
    // count pins and low frequency clock
    input  wire  logic        first_count_input,
    input  wire  logic        second_count_input,
    input  wire  logic        third_count_input,
    input  wire  logic        low_freq_clock,
    // service entry strobes and flags
    input  wire  logic        timer_a_isr_enter,
    input  wire  logic        timer_b_isr_enter,
    output logic              timer_a_overflow_flag,
    output logic              timer_b_overflow_flag
);
    import tmc_pkg::*;

    logic        tr_a, tr_b;
    tmc_ab_cfg_t cfg_a, cfg_b;
    tmc_c_ctl_t  cctl;
    logic [15:0] cnt_a, cnt_b, cnt_c, rld;
    logic [15:0] cap [TMC_NCAP];
    logic        acc, wr_en, hit;
    logic [15:0] rd_val;
    logic        w_ctl, w_cfg, w_alo, w_ahi, w_blo, w_bhi;
    logic        w_cctl, w_clo, w_chi, w_rlo, w_rhi;
    logic [3:0]  presc;
    logic        half, tick12, tick24, tick_c;
    logic [3:0]  pin_in, sy1, sy2, sy3, lvl, lvl_q;
    logic        fall_a, fall_b, fall_c, fall_c_d;
    logic        lf_div, lf_div_q, trig_fall;
    logic        split_a, inc_a, inc_ah, inc_b, inc_c;
    logic        ovf_a, ovf_ah, ovf_b, ovf_c, set_b;

    function automatic logic fell(input logic p, input logic c);
        return p & ~c;
    endfunction

    function automatic logic [7:0] cap_ofs(input int k);
        return 8'(TMC_CAP0_OFS + 8'(k) * TMC_CAP_STEP);
    endfunction

    // next count of timer a or b for one step
    function automatic logic [15:0] ab_next(input logic [15:0] c, input tmc_mode_t m);
        logic [12:0] c13;
        c13 = {c[15:8], c[4:0]} + 13'h1;
        case (m)
            TMC_M13: ab_next = {c13[12:5], c[7:5], c13[4:0]};
            TMC_M16: ab_next = c + 16'h1;
            TMC_M8R: ab_next = {c[15:8], (&c[7:0]) ? c[15:8] : c[7:0] + 8'h1};
            default: ab_next = {c[15:8], c[7:0] + 8'h1};
        endcase
    endfunction

    function automatic logic ab_full(input logic [15:0] c, input tmc_mode_t m);
        case (m)
            TMC_M13: ab_full = &{c[15:8], c[4:0]};
            TMC_M16: ab_full = &c;
            default: ab_full = &c[7:0];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer in second access cycle
    assign acc    = psel & penable & ~pready;
    assign wr_en  = psel & penable & pready & pwrite;
    assign w_ctl  = wr_en && paddr == TMC_CTRL_OFS;
    assign w_cfg  = wr_en && paddr == TMC_CFG_OFS;
    assign w_alo  = wr_en && paddr == TMC_ALO_OFS;
    assign w_ahi  = wr_en && paddr == TMC_AHI_OFS;
    assign w_blo  = wr_en && paddr == TMC_BLO_OFS;
    assign w_bhi  = wr_en && paddr == TMC_BHI_OFS;
    assign w_cctl = wr_en && paddr == TMC_CCTL_OFS;
    assign w_clo  = wr_en && paddr == TMC_CLO_OFS;
    assign w_chi  = wr_en && paddr == TMC_CHI_OFS;
    assign w_rlo  = wr_en && paddr == TMC_RLO_OFS;
    assign w_rhi  = wr_en && paddr == TMC_RHI_OFS;

    always_comb begin
        rd_val = TMC_RST_WORD;
        hit    = 1'b1;
        case (paddr)
            TMC_CTRL_OFS: rd_val[7:0] = {timer_b_overflow_flag, tr_b,
                                          timer_a_overflow_flag, tr_a, 4'h0};
            TMC_CFG_OFS:  rd_val[7:0] = {cfg_b, cfg_a};
            TMC_ALO_OFS:  rd_val[7:0] = cnt_a[7:0];
            TMC_AHI_OFS:  rd_val[7:0] = cnt_a[15:8];
            TMC_BLO_OFS:  rd_val[7:0] = cnt_b[7:0];
            TMC_BHI_OFS:  rd_val[7:0] = cnt_b[15:8];
            TMC_CCTL_OFS: rd_val[7:0] = cctl;
            TMC_CLO_OFS:  rd_val[7:0] = cnt_c[7:0];
            TMC_CHI_OFS:  rd_val[7:0] = cnt_c[15:8];
            TMC_RLO_OFS:  rd_val[7:0] = rld[7:0];
            TMC_RHI_OFS:  rd_val[7:0] = rld[15:8];
            default:      hit = 1'b0;
        endcase
        for (int k = 0; k < TMC_NCAP; k++) begin
            if (paddr == cap_ofs(k)) begin
                rd_val = cap[k];
                hit    = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~hit;
            if (acc) begin
                prdata <= {16'h0000, rd_val};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tr_a  <= 1'b0;
            tr_b  <= 1'b0;
            cfg_a <= tmc_ab_cfg_t'(4'h0);
            cfg_b <= tmc_ab_cfg_t'(4'h0);
            cctl  <= tmc_c_ctl_t'(TMC_RST_BYTE);
            rld   <= TMC_RST_WORD;
        end else begin
            if (w_ctl) begin
                tr_a <= pwdata[TMC_TR_A_BIT];
                tr_b <= pwdata[TMC_TR_B_BIT];
            end
            if (w_cfg) begin
                {cfg_b, cfg_a} <= pwdata[7:0];
            end
            if (w_cctl) begin
                cctl <= tmc_c_ctl_t'(pwdata[7:0]);
            end
            if (w_rlo) begin
                rld[7:0] <= pwdata[7:0];
            end
            if (w_rhi) begin
                rld[15:8] <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler: 1/12 tick and 1/24 tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= TMC_PRESC_ZERO;
            half  <= 1'b0;
        end else begin
            presc <= tick12 ? TMC_PRESC_ZERO : presc + 4'h1;
            half  <= half ^ tick12;
        end
    end
    assign tick12 = presc == TMC_PRESC_LAST;
    assign tick24 = tick12 & half;
    assign tick_c = cctl.ps ? tick24 : tick12;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: level accepted once stages two and three agree
    assign pin_in = {low_freq_clock, third_count_input, second_count_input,
                     first_count_input};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1   <= 4'h0;
            sy2   <= 4'h0;
            sy3   <= 4'h0;
            lvl   <= 4'h0;
            lvl_q <= 4'h0;
        end else begin
            sy1   <= pin_in;
            sy2   <= sy1;
            sy3   <= sy2;
            lvl   <= (sy2 & sy3) | (lvl & (sy2 ^ sy3));
            lvl_q <= lvl;
        end
    end
    assign fall_a = fell(lvl_q[0], lvl[0]);
    assign fall_b = fell(lvl_q[1], lvl[1]);
    assign fall_c = fell(lvl_q[2], lvl[2]);

    // reload trigger: low frequency clock halved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_div   <= 1'b0;
            lf_div_q <= 1'b0;
            fall_c_d <= 1'b0;
        end else begin
            lf_div   <= lf_div ^ (lvl[3] & ~lvl_q[3]);
            lf_div_q <= lf_div;
            fall_c_d <= fall_c;
        end
    end
    assign trig_fall = fell(lf_div_q, lf_div);

    ////////////////////////////////////////////////////////////////////////
    // timers a and b
    assign split_a = cfg_a.mode == TMC_SPLIT;
    assign inc_a   = tr_a & (cfg_a.ct ? fall_a : tick12);
    assign inc_ah  = split_a & tr_b & tick12;
    // b runs on regardless of its run bit while a is split
    assign inc_b   = (split_a | tr_b) & cfg_b.mode != TMC_SPLIT
                     & (cfg_b.ct ? fall_b : tick12);
    assign ovf_a   = inc_a & ab_full(cnt_a, cfg_a.mode);
    assign ovf_ah  = inc_ah & (&cnt_a[15:8]);
    assign ovf_b   = inc_b & ab_full(cnt_b, cfg_b.mode);
    assign set_b   = split_a ? ovf_ah : ovf_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_a <= TMC_RST_WORD;
        end else if (w_alo) begin
            cnt_a[7:0] <= pwdata[7:0];
        end else if (w_ahi) begin
            cnt_a[15:8] <= pwdata[7:0];
        end else begin
            if (inc_a) begin
                cnt_a <= ab_next(cnt_a, cfg_a.mode);
            end
            if (inc_ah) begin
                cnt_a[15:8] <= cnt_a[15:8] + 8'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_b <= TMC_RST_WORD;
        end else if (w_blo) begin
            cnt_b[7:0] <= pwdata[7:0];
        end else if (w_bhi) begin
            cnt_b[15:8] <= pwdata[7:0];
        end else if (inc_b) begin
            cnt_b <= ab_next(cnt_b, cfg_b.mode);
        end
    end

    // overflow flags: a set wins over any clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_a_overflow_flag <= 1'b0;
            timer_b_overflow_flag <= 1'b0;
        end else begin
            timer_a_overflow_flag <= ovf_a | (w_ctl ? pwdata[TMC_TF_A_BIT]
                : timer_a_overflow_flag & ~timer_a_isr_enter);
            timer_b_overflow_flag <= set_b | (w_ctl ? pwdata[TMC_TF_B_BIT]
                : timer_b_overflow_flag & ~timer_b_isr_enter);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer c
    always_comb begin
        case (cctl.sel)
            TMC_C_CLK:   inc_c = tick_c;
            TMC_C_EVT:   inc_c = fall_c_d;
            TMC_C_GATED: inc_c = tick_c & lvl[2];
            default:     inc_c = 1'b0;
        endcase
    end
    assign ovf_c = inc_c & (&cnt_c);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_c <= TMC_RST_WORD;
        end else if (w_clo) begin
            cnt_c[7:0] <= pwdata[7:0];
        end else if (w_chi) begin
            cnt_c[15:8] <= pwdata[7:0];
        end else if (cctl.rmode == TMC_RLD_M1 && trig_fall) begin
            cnt_c <= rld;
        end else if (cctl.rmode == TMC_RLD_M0 && ovf_c) begin
            cnt_c <= rld;
        end else if (inc_c) begin
            cnt_c <= cnt_c + 16'h1;
        end
    end

    // any write to a capture slot latches the running count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < TMC_NCAP; k++) begin
                cap[k] <= TMC_RST_WORD;
            end
        end else begin
            for (int k = 0; k < TMC_NCAP; k++) begin
                if (wr_en && paddr == cap_ofs(k)) begin
                    cap[k] <= cnt_c;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tick_twelve: assert property (
        tick12 |-> ##1 !tick12 ##11 tick12) else $error("tick12 period wrong");
    a_tick_double: assert property (
        tick24 |-> ##1 !tick24 ##23 tick24) else $error("tick24 period wrong");
    a_a_timer_step: assert property (
        (inc_a && !cfg_a.ct && cfg_a.mode == TMC_M16 && !w_alo && !w_ahi)
        |=> cnt_a == 16'($past(cnt_a) + 16'h1)) else $error("timer a step wrong");
    a_edge_two_clk: assert property (
        fall_a |=> !fall_a) else $error("edge detected twice");
    a_pin_to_step: assert property (
        (tr_a && cfg_a.ct && $fell(sy2[0]) && !sy3[0] == 1'b0)
        |-> ##2 fall_a) else $error("count pin edge missed");
    a_m13_upper: assert property (
        (inc_a && cfg_a.mode == TMC_M13 && !w_alo)
        |=> cnt_a[7:5] == $past(cnt_a[7:5])) else $error("mode 0 upper bits moved");
    a_m8_reload: assert property (
        (inc_a && cfg_a.mode == TMC_M8R && &cnt_a[7:0] && !w_alo && !w_ahi)
        |=> cnt_a[7:0] == $past(cnt_a[15:8])) else $error("mode 2 reload wrong");
    a_b_split_hold: assert property (
        (cfg_b.mode == TMC_SPLIT && !w_blo && !w_bhi)
        |=> $stable(cnt_b)) else $error("timer b moved in mode 3");
    a_c_evt_delay: assert property (
        (fall_c && cctl.sel == TMC_C_EVT && !w_cctl)
        |=> inc_c) else $error("event count not one cycle after edge");
    a_c_gate_low: assert property (
        (cctl.sel == TMC_C_GATED && !lvl[2]) |-> !inc_c) else $error("gated count ran");
    a_c_ovf_reload: assert property (
        (ovf_c && cctl.rmode == TMC_RLD_M0 && !w_clo && !w_chi)
        |=> cnt_c == $past(rld)) else $error("overflow reload missed");
    a_c_trig_reload: assert property (
        (trig_fall && cctl.rmode == TMC_RLD_M1 && !w_clo && !w_chi)
        |=> cnt_c == $past(rld)) else $error("trigger reload missed");
    a_flag_clear: assert property (
        (timer_a_isr_enter && !ovf_a && !w_ctl)
        |=> !timer_a_overflow_flag) else $error("flag not cleared on entry");
    a_flag_set: assert property (
        ovf_a |=> timer_a_overflow_flag) else $error("overflow flag not set");

    c_a_overflow: cover property (ovf_a);
    c_b_split_run: cover property (split_a && inc_b);
    c_c_trig_load: cover property (trig_fall && cctl.rmode == TMC_RLD_M1);
    c_c_evt_count: cover property (cctl.sel == TMC_C_EVT && inc_c);
endmodule

// ### bench/tmc_pin_model.sv
// far-side model of the count pins and the low frequency clock
`timescale 1ns/1ps
module tmc_pin_model (
    // clock
    input  wire logic pclk,
    // driven pins
    output logic      first_count_input,
    output logic      second_count_input,
    output logic      third_count_input,
    output logic      low_freq_clock
);
    logic [2:0] pin;

    assign first_count_input  = pin[0];
    assign second_count_input = pin[1];
    assign third_count_input  = pin[2];

    initial begin
        pin            = 3'b111;
        low_freq_clock = 1'b0;
    end

    // falling pulses, each level held two clocks
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge pclk);
            pin[idx] <= 1'b0;
            repeat (2) @(posedge pclk);
            pin[idx] <= 1'b1;
            @(posedge pclk);
        end
    endtask

    task automatic set_level(input int idx, input logic v);
        @(posedge pclk);
        pin[idx] <= v;
    endtask

    // one full low frequency period, slow against pclk
    task automatic lf_cycle();
        @(posedge pclk);
        low_freq_clock <= 1'b1;
        repeat (8) @(posedge pclk);
        low_freq_clock <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the timer/counter block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module tb;
    import tmc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, isr_a, isr_b, flag_a, flag_b;
    logic        pin_a, pin_b, pin_c, lfclk, last_err;
    logic [15:0] q;
    int          mismatches, checks_done, cyc, stamp;

    tmc_timers dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_count_input(pin_a), .second_count_input(pin_b),
        .third_count_input(pin_c), .low_freq_clock(lfclk), .timer_a_isr_enter(isr_a),
        .timer_b_isr_enter(isr_b), .timer_a_overflow_flag(flag_a),
        .timer_b_overflow_flag(flag_b));
    tmc_pin_model pins (.pclk(pclk), .first_count_input(pin_a), .second_count_input(pin_b),
        .third_count_input(pin_c), .low_freq_clock(lfclk));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q        = prdata[15:0];
        last_err = pslverr;
        stamp    = cyc;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
        apb(a, 1'b0, 8'h00);
        `CHK(nm, exp, q)
    endtask

    // count gained over exactly 240 clocks
    task automatic rate(input logic [7:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] v1;
        int         t1;
        apb(a, 1'b0, 8'h00);
        v1 = q[7:0];
        t1 = stamp;
        while (cyc < t1 + 236) @(posedge pclk);
        apb(a, 1'b0, 8'h00);
        `CHK(nm, exp, 8'(q[7:0] - v1))
    endtask

    task automatic service(input logic b);
        @(posedge pclk);
        if (b) isr_b <= 1'b1; else isr_a <= 1'b1;
        @(posedge pclk);
        isr_a <= 1'b0;
        isr_b <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic results();
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite, isr_a, isr_b} = '0;
        paddr  = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 11; i++) rd(8'(4 * i), 16'h0000, "reset value");
        rd(8'h3c, 16'h0000, "unmapped data");
        `CHK("unmapped err", 1'b1, last_err)
        // counter mode on both pins, 16-bit
        wr(TMC_CFG_OFS, 8'h55);
        wr(TMC_CTRL_OFS, 8'h50);
        pins.pulse(0, 5);
        pins.pulse(1, 3);
        repeat (8) @(posedge pclk);
        rd(TMC_ALO_OFS, 16'h0005, "a events");
        rd(TMC_BLO_OFS, 16'h0003, "b events");
        // timer b overflow flag and its service clear
        wr(TMC_BLO_OFS, 8'hff);
        wr(TMC_BHI_OFS, 8'hff);
        pins.pulse(1, 1);
        repeat (8) @(posedge pclk);
        `CHK("flag b set", 1'b1, flag_b)
        service(1'b1);
        `CHK("flag b clr", 1'b0, flag_b)
        wr(TMC_ALO_OFS, 8'hff);
        wr(TMC_AHI_OFS, 8'h12);
        pins.pulse(0, 1);
        repeat (8) @(posedge pclk);
        rd(TMC_ALO_OFS, 16'h0000, "m1 low");
        rd(TMC_AHI_OFS, 16'h0013, "m1 high");
        // 13-bit mode overflow
        wr(TMC_CFG_OFS, 8'h54);
        wr(TMC_AHI_OFS, 8'hff);
        wr(TMC_ALO_OFS, 8'hff);
        pins.pulse(0, 1);
        repeat (8) @(posedge pclk);
        rd(TMC_ALO_OFS, 16'h00e0, "m0 low");
        rd(TMC_AHI_OFS, 16'h0000, "m0 high");
        `CHK("flag a set", 1'b1, flag_a)
        rd(TMC_CTRL_OFS, 16'h0070, "ctrl flag");
        service(1'b0);
        `CHK("flag a clr", 1'b0, flag_a)
        // 8-bit auto reload
        wr(TMC_CFG_OFS, 8'h56);
        wr(TMC_ALO_OFS, 8'hff);
        wr(TMC_AHI_OFS, 8'ha5);
        pins.pulse(0, 1);
        repeat (8) @(posedge pclk);
        rd(TMC_ALO_OFS, 16'h00a5, "m2 reload");
        `CHK("m2 flag", 1'b1, flag_a)
        service(1'b0);
        // split mode: b holds in mode three, runs beside split in mode one
        wr(TMC_CFG_OFS, 8'h37);
        wr(TMC_ALO_OFS, 8'h00);
        pins.pulse(0, 2);
        repeat (8) @(posedge pclk);
        rd(TMC_ALO_OFS, 16'h0002, "split low");
        rate(TMC_BLO_OFS, 8'h00, "b held");
        wr(TMC_CFG_OFS, 8'h17);
        rate(TMC_BLO_OFS, 8'd20, "b beside split");
        wr(TMC_CFG_OFS, 8'h11);
        rate(TMC_ALO_OFS, 8'd20, "a timer");
        // timer c clock, prescale and gate
        wr(TMC_CCTL_OFS, 8'h01);
        rate(TMC_CLO_OFS, 8'd20, "c div12");
        wr(TMC_CCTL_OFS, 8'h81);
        rate(TMC_CLO_OFS, 8'd10, "c div24");
        wr(TMC_CCTL_OFS, 8'h03);
        rate(TMC_CLO_OFS, 8'd20, "gate open");
        pins.set_level(2, 1'b0);
        repeat (8) @(posedge pclk);
        rate(TMC_CLO_OFS, 8'd0, "gate shut");
        pins.set_level(2, 1'b1);
        wr(TMC_CCTL_OFS, 8'h02);
        wr(TMC_CLO_OFS, 8'h00);
        pins.pulse(2, 4);
        repeat (8) @(posedge pclk);
        rd(TMC_CLO_OFS, 16'h0004, "c events");
        // reload on overflow
        wr(TMC_CCTL_OFS, 8'h11);
        wr(TMC_RLO_OFS, 8'h34);
        wr(TMC_RHI_OFS, 8'h12);
        wr(TMC_CLO_OFS, 8'hfe);
        wr(TMC_CHI_OFS, 8'hff);
        repeat (60) @(posedge pclk);
        rd(TMC_CHI_OFS, 16'h0012, "ovf reload");
        // reload on trigger from halved low frequency clock
        wr(TMC_CCTL_OFS, 8'h18);
        wr(TMC_CLO_OFS, 8'h00);
        wr(TMC_CHI_OFS, 8'h00);
        wr(TMC_RLO_OFS, 8'hcd);
        wr(TMC_RHI_OFS, 8'hab);
        pins.lf_cycle();
        rd(TMC_CHI_OFS, 16'h0000, "half trig");
        pins.lf_cycle();
        rd(TMC_CHI_OFS, 16'h00ab, "trig high");
        rd(TMC_CLO_OFS, 16'h00cd, "trig low");
        rd(TMC_RHI_OFS, 16'h00ab, "reload reg");
        for (int i = 0; i < TMC_NCAP; i++) begin
            wr(8'(TMC_CAP0_OFS + 4 * i), 8'h00);
            rd(8'(TMC_CAP0_OFS + 4 * i), 16'habcd, "capture");
        end
        results();
    end
endmodule
